// >>> verilog/diag_pkg.sv
// Constants for the diagnostic blanking and flag latch block.
// Summary of operation
// - Sensor drive runs at one of four frequencies chosen by a register.
// - Ten-bit I and Q samples accumulate into sixteen-bit readable values.
// - Monitor inputs are synchronised to mclk and filtered against spikes.
// - A blanked monitor flags only after staying asserted for the blanking count.
// - Every blanked monitor has its own up/down qualification counter.
// - Qualification counters step once per transmitter sine period.
// - Blanked status bits stay set until the status word is read.
// - Read code 0x2B returns the blanking count register.
// - Signature check starts after memory reset, power-on and divider update.
// - Signature mismatch latches the signature-fail bit until the next check.
// - Missing or invalid external clock sets the missing-clock bit.
// - Main sensor multiplexer is open while a pin short test runs.
// - Host picks the short test pin pair through the pin select register.
// - Comparator reporting too low pin resistance sets the pin-short flag.
// - Window comparators out of range set their voltage status flags.
// - Driver overcurrent comparators set sense or shield overcurrent flags.
// - Bit 4 of each command byte marks a write, clear marks a read.
// - Read code 0x02 returns the status word with all flags.
package diag_pkg;
  localparam int          DATA_W      = 16;
  localparam int          WR_BIT      = 4;
  localparam logic [7:0]  RD_STATUS   = 8'h02;
  localparam logic [7:0]  RD_I_DATA   = 8'h03;
  localparam logic [7:0]  RD_Q_DATA   = 8'h04;
  localparam logic [7:0]  RD_DIVIDER  = 8'h20;
  localparam logic [7:0]  RD_DRIVE_FREQUENCY_SELECT     = 8'h27;
  localparam logic [7:0]  RD_BLANK    = 8'h2B;
  localparam logic [7:0]  RD_PINSEL   = 8'h2C;
  localparam logic [15:0] BLANK_RESET = 16'h0004;
  localparam logic [15:0] PINSEL_RESET = 16'h0000;
  localparam logic [2:0]  DIV_RESET   = 3'h0;
  localparam logic [1:0]  DRIVE_FREQUENCY_SELECT_RESET  = 2'h0;
  // Pin select layout: plus pin, minus pin, test enable.
  localparam int          PLUS_LSB    = 0;
  localparam int          MINUS_LSB   = 4;
  localparam int          PIN_W       = 4;
  localparam int          TEST_EN_BIT = 8;
  // Status word bit positions.
  localparam int          ST_DIV_LSB  = 13;
  localparam int          ST_SIG      = 12;
  localparam int          ST_SHORT    = 11;
  localparam int          ST_REG      = 9;
  localparam int          ST_MISSING_CLOCK_FLAG     = 1;
  localparam int          N_MON       = 8;
  // Blanked monitors: filter, shield oc, sense oc, sense drive, shield drive, I, Q, buffer.
  localparam int          MON_BIT [N_MON] = '{10, 8, 7, 5, 4, 3, 2, 0};
  // Drive periods per frequency code and the mclk period.
  localparam int          MCLK_NS     = 40;
  localparam int          PERIOD_NS [4] = '{22000, 14000, 10000, 8000};
  localparam int          HALF_0      = PERIOD_NS[0] / MCLK_NS / 2;
  localparam int          HALF_1      = PERIOD_NS[1] / MCLK_NS / 2;
  localparam int          HALF_2      = PERIOD_NS[2] / MCLK_NS / 2;
  localparam int          HALF_3      = PERIOD_NS[3] / MCLK_NS / 2;
endpackage : diag_pkg

// >>> verilog/diag_supervisor.sv
// Diagnostic supervisor: blanking counters, status flag latch and register port.
`timescale 1ns/1ns
module diag_supervisor (
  input  wire logic                     mclk,
  input  wire logic                     rst_b,
  input  wire logic                     cmd_valid,
  input  wire logic [7:0]               cmd_code,
  input  wire logic [diag_pkg::DATA_W-1:0] cmd_wdata,
  output logic      [diag_pkg::DATA_W-1:0] rd_data,
  output logic                          rd_valid,
  input  wire logic [diag_pkg::N_MON-1:0] monitor_in,
  input  wire logic                     regulator_fail_in,
  input  wire logic                     pin_short_in,
  input  wire logic                     clock_invalid_in,
  input  wire logic                     mem_reset_pulse,
  input  wire logic                     sig_done,
  input  wire logic                     sig_match,
  input  wire logic                     adc_valid,
  input  wire logic                     adc_q_sel,
  input  wire logic [9:0]               adc_sample,
  output logic                          sig_check_start,
  output logic                          drive_wave,
  output logic                          sine_tick,
  output logic                          main_mux_open,
  output logic [diag_pkg::PIN_W-1:0]    diag_mux_plus,
  output logic [diag_pkg::PIN_W-1:0]    diag_mux_minus
);
  import diag_pkg::*;

  logic              rst_q1;
  logic              rst_n;
  logic [15:0]       diag_blanking_count;
  logic [15:0]       short_test_pin_select;
  logic [2:0]        clock_divider_setting;
  logic [1:0]        drive_frequency_select;
  logic [15:0]       status_flags;
  logic [15:0]       i_acc;
  logic [15:0]       q_acc;
  logic [8:0]        half_cnt;
  logic [8:0]        half_lim;
  logic [N_MON-1:0]  mon_s1;
  logic [N_MON-1:0]  mon_s2;
  logic [2:0]        lone_s1;
  logic [2:0]        lone_s2;
  logic [N_MON-1:0]  qualified;
  logic [15:0]       set_vec;
  logic              is_write;
  logic              wr_blank;
  logic              wr_pinsel;
  logic              wr_div;
  logic              wr_drive_frequency_select;
  logic              rd_status;
  logic              rd_i;
  logic              rd_q;
  logic              next_sig_start;
  logic [15:0]       next_rd_data;

  // Reset is released through two flops; everything else uses rst_n.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rst_q1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n  <= rst_q1;
    end
  end

  // Command decode.
  assign is_write  = cmd_valid && cmd_code[WR_BIT];
  assign wr_blank  = is_write && (cmd_code == (RD_BLANK | 8'h10));
  assign wr_pinsel = is_write && (cmd_code == (RD_PINSEL | 8'h10));
  assign wr_div    = is_write && (cmd_code == (RD_DIVIDER | 8'h10));
  assign wr_drive_frequency_select   = is_write && (cmd_code == (RD_DRIVE_FREQUENCY_SELECT | 8'h10));
  assign rd_status = cmd_valid && (cmd_code == RD_STATUS);
  assign rd_i      = cmd_valid && (cmd_code == RD_I_DATA);
  assign rd_q      = cmd_valid && (cmd_code == RD_Q_DATA);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      diag_blanking_count    <= BLANK_RESET;
      short_test_pin_select  <= PINSEL_RESET;
      clock_divider_setting  <= DIV_RESET;
      drive_frequency_select <= DRIVE_FREQUENCY_SELECT_RESET;
    end else begin
      if (wr_blank) begin
        diag_blanking_count <= cmd_wdata;
      end
      if (wr_pinsel) begin
        short_test_pin_select <= cmd_wdata;
      end
      if (wr_div) begin
        clock_divider_setting <= cmd_wdata[2:0];
      end
      if (wr_drive_frequency_select) begin
        drive_frequency_select <= cmd_wdata[1:0];
      end
    end
  end

  // Pin short test routing; the main mux is held open for the whole test.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      main_mux_open  <= 1'b0;
      diag_mux_plus  <= '0;
      diag_mux_minus <= '0;
    end else begin
      main_mux_open  <= short_test_pin_select[TEST_EN_BIT];
      diag_mux_plus  <= short_test_pin_select[PLUS_LSB +: PIN_W];
      diag_mux_minus <= short_test_pin_select[MINUS_LSB +: PIN_W];
    end
  end

  // Drive divider: wave toggles every half period, tick on each rising edge.
  always_comb begin
    case (drive_frequency_select)
      2'd0:    half_lim = 9'(HALF_0 - 1);
      2'd1:    half_lim = 9'(HALF_1 - 1);
      2'd2:    half_lim = 9'(HALF_2 - 1);
      default: half_lim = 9'(HALF_3 - 1);
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      half_cnt   <= '0;
      drive_wave <= 1'b0;
      sine_tick  <= 1'b0;
    end else begin
      sine_tick <= 1'b0;
      if (half_cnt >= half_lim) begin
        half_cnt   <= '0;
        drive_wave <= !drive_wave;
        sine_tick  <= !drive_wave;
      end else begin
        half_cnt <= half_cnt + 9'd1;
      end
    end
  end

  // Two-flop synchronisers; only the second stage is looked at.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mon_s1  <= '0;
      mon_s2  <= '0;
      lone_s1 <= '0;
      lone_s2 <= '0;
    end else begin
      mon_s1  <= monitor_in;
      mon_s2  <= mon_s1;
      lone_s1 <= {regulator_fail_in, pin_short_in, clock_invalid_in};
      lone_s2 <= lone_s1;
    end
  end

  // One up/down counter per blanked monitor, stepped on the sine tick.
  for (genvar m = 0; m < N_MON; m++) begin : g_qual
    logic [15:0] cnt;
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        cnt <= '0;
      end else if (sine_tick) begin
        if (mon_s2[m]) begin
          if (cnt < diag_blanking_count) begin
            cnt <= cnt + 16'd1;
          end
        end else if (cnt != 16'd0) begin
          cnt <= cnt - 16'd1;
        end
      end
    end
    // A spike shorter than the blanking count never reaches the flag.
    assign qualified[m] = mon_s2[m] && (cnt >= diag_blanking_count);
  end

  // Events that set status bits this cycle.
  always_comb begin
    set_vec = '0;
    for (int m = 0; m < N_MON; m++) begin
      set_vec[MON_BIT[m]] = qualified[m];
    end
    set_vec[ST_REG]   = lone_s2[2];
    set_vec[ST_SHORT] = lone_s2[1];
    set_vec[ST_MISSING_CLOCK_FLAG]  = lone_s2[0];
  end

  // Power-on is treated as one more check request, so the first check runs after reset.
  logic power_pending;
  assign next_sig_start = mem_reset_pulse || wr_div || power_pending;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      power_pending   <= 1'b1;
      sig_check_start <= 1'b0;
    end else begin
      power_pending   <= 1'b0;
      sig_check_start <= next_sig_start;
    end
  end

  // Flag latch: set wins over the read clear; signature bit has its own clear.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      status_flags <= '0;
    end else begin
      for (int b = 0; b < 16; b++) begin
        if (b == ST_SIG) begin
          if (sig_done && !sig_match) begin
            status_flags[b] <= 1'b1;
          end else if (next_sig_start) begin
            status_flags[b] <= 1'b0;
          end
        end else if (set_vec[b]) begin
          status_flags[b] <= 1'b1;
        end else if (rd_status) begin
          status_flags[b] <= 1'b0;
        end
      end
    end
  end

  // Accumulators clear when read; a sample in the same cycle starts the new sum.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      i_acc <= '0;
      q_acc <= '0;
    end else begin
      if (adc_valid && !adc_q_sel) begin
        i_acc <= (rd_i ? 16'd0 : i_acc) + {6'd0, adc_sample};
      end else if (rd_i) begin
        i_acc <= '0;
      end
      if (adc_valid && adc_q_sel) begin
        q_acc <= (rd_q ? 16'd0 : q_acc) + {6'd0, adc_sample};
      end else if (rd_q) begin
        q_acc <= '0;
      end
    end
  end

  // Read data; the divider field of the status word is live.
  always_comb begin
    next_rd_data = '0;
    if (cmd_code == RD_STATUS) begin
      next_rd_data = status_flags;
      next_rd_data[ST_DIV_LSB +: 3] = clock_divider_setting;
    end else if (cmd_code == RD_BLANK) begin
      next_rd_data = diag_blanking_count;
    end else if (cmd_code == RD_PINSEL) begin
      next_rd_data = short_test_pin_select;
    end else if (cmd_code == RD_DIVIDER) begin
      next_rd_data = {13'd0, clock_divider_setting};
    end else if (cmd_code == RD_DRIVE_FREQUENCY_SELECT) begin
      next_rd_data = {14'd0, drive_frequency_select};
    end else if (cmd_code == RD_I_DATA) begin
      next_rd_data = i_acc;
    end else if (cmd_code == RD_Q_DATA) begin
      next_rd_data = q_acc;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_valid <= 1'b0;
      rd_data  <= '0;
    end else begin
      rd_valid <= cmd_valid && !cmd_code[WR_BIT];
      if (cmd_valid && !cmd_code[WR_BIT]) begin
        rd_data <= next_rd_data;
      end
    end
  end

  // Helper: cycles since last tick, to check the drive period.
  logic [9:0] tick_gap;
  logic       gap_ok;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tick_gap <= '0;
      gap_ok   <= 1'b0;
    end else begin
      tick_gap <= sine_tick ? 10'd1 : tick_gap + 10'd1;
      gap_ok   <= sine_tick ? 1'b1 : (gap_ok && !wr_drive_frequency_select);
    end
  end

  blank_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
    cmd_valid && cmd_code == RD_BLANK |=> rd_valid && rd_data == $past(diag_blanking_count))
    else $error("blanking count read returned wrong value");
  status_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rd_status |=> rd_valid && rd_data[ST_SHORT] == $past(status_flags[ST_SHORT]))
    else $error("status read returned wrong flag");
  flag_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    status_flags[MON_BIT[0]] && !rd_status |=> status_flags[MON_BIT[0]])
    else $error("blanked flag dropped without a status read");
  qual_flag_a: assert property (@(posedge mclk) disable iff (!rst_n)
    qualified[0] |=> status_flags[MON_BIT[0]])
    else $error("qualified fault did not set its flag");
  read_keep_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rd_status && qualified[1] |=> status_flags[MON_BIT[1]])
    else $error("qualified flag cleared by status read");
  cnt_step_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !sine_tick |=> $stable(g_qual[0].cnt))
    else $error("qualification counter moved without a tick");
  tick_period_a: assert property (@(posedge mclk) disable iff (!rst_n)
    sine_tick && gap_ok && $stable(drive_frequency_select)
      |-> tick_gap == 10'(2 * (32'(half_lim) + 1)))
    else $error("drive tick period wrong");
  sig_latch_a: assert property (@(posedge mclk) disable iff (!rst_n)
    sig_done && !sig_match |=> status_flags[ST_SIG] [*2] or ##1 sig_check_start)
    else $error("signature failure not latched");
  div_start_a: assert property (@(posedge mclk) disable iff (!rst_n)
    wr_div |=> sig_check_start)
    else $error("divider update did not start signature check");
  mux_open_a: assert property (@(posedge mclk) disable iff (!rst_n)
    wr_pinsel |=> ##1 main_mux_open == $past(cmd_wdata[TEST_EN_BIT], 2))
    else $error("main mux open does not follow short test enable");
  short_flag_a: assert property (@(posedge mclk) disable iff (!rst_n)
    lone_s2[1] |=> status_flags[ST_SHORT])
    else $error("pin short not flagged");
endmodule : diag_supervisor

// >>> testbench/host_model.sv
// Host controller model that issues commands on the supervisor's register port.
`timescale 1ns/1ns
module host_model (
  input  wire logic                        mclk,
  output logic                             cmd_valid,
  output logic [7:0]                       cmd_code,
  output logic [diag_pkg::DATA_W-1:0]      cmd_wdata,
  input  wire logic [diag_pkg::DATA_W-1:0] rd_data,
  input  wire logic                        rd_valid
);
  import diag_pkg::*;

  initial begin
    cmd_valid = 1'b0;
    cmd_code  = 8'h00;
    cmd_wdata = 16'h0000;
  end

  // Idle lines show the inverse of the last command so a stale value is never read as live.
  task automatic issue(input logic [7:0] code, input logic [15:0] wdata);
    @(posedge mclk);
    cmd_valid <= 1'b1;
    cmd_code  <= code;
    cmd_wdata <= wdata;
    @(posedge mclk);
    cmd_valid <= 1'b0;
    cmd_code  <= ~code;
    cmd_wdata <= ~wdata;
  endtask : issue

  // Pin pair and drive frequency choices are programmed here by the host.
  task automatic write_reg(input logic [7:0] addr, input logic [15:0] wdata);
    issue(addr | (8'h01 << WR_BIT), wdata);
  endtask : write_reg

  task automatic read_reg(input logic [7:0] addr, output logic [15:0] data, output logic ok);
    ok   = 1'b0;
    data = 16'h0000;
    issue(addr & ~(8'h01 << WR_BIT), 16'h0000);
    for (int i = 0; i < 4 && !ok; i++) begin
      #1;
      if (rd_valid === 1'b1) begin
        ok   = 1'b1;
        data = rd_data;
      end else begin
        @(posedge mclk);
      end
    end
  endtask : read_reg
endmodule : host_model

// >>> testbench/diag_blanking_and_flag_latch_tb.sv
// Self-checking testbench for the diagnostic supervisor.
`timescale 1ns/1ns
module diag_blanking_and_flag_latch_tb;
  import diag_pkg::*;
  logic        mclk, rst_b, cmd_valid, rd_valid, sig_check_start, drive_wave, sine_tick;
  logic        regulator_fail_in, pin_short_in, clock_invalid_in, mem_reset_pulse;
  logic        sig_done, sig_match, adc_valid, adc_q_sel, main_mux_open;
  logic [7:0]  cmd_code, monitor_in;
  logic [15:0] cmd_wdata, rd_data;
  logic [9:0]  adc_sample;
  logic [3:0]  diag_mux_plus, diag_mux_minus;
  int          err_count, total_checks, n;

  diag_supervisor u_dut (.mclk(mclk), .rst_b(rst_b), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rd_data(rd_data), .rd_valid(rd_valid),
    .monitor_in(monitor_in), .regulator_fail_in(regulator_fail_in),
    .pin_short_in(pin_short_in), .clock_invalid_in(clock_invalid_in),
    .mem_reset_pulse(mem_reset_pulse), .sig_done(sig_done), .sig_match(sig_match),
    .adc_valid(adc_valid), .adc_q_sel(adc_q_sel), .adc_sample(adc_sample),
    .sig_check_start(sig_check_start), .drive_wave(drive_wave), .sine_tick(sine_tick),
    .main_mux_open(main_mux_open), .diag_mux_plus(diag_mux_plus),
    .diag_mux_minus(diag_mux_minus));
  host_model u_host (.mclk(mclk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata), .rd_data(rd_data), .rd_valid(rd_valid));

  always #20 mclk = ~mclk;

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic expect_rd(input logic [7:0] addr, input string name, input logic [15:0] exp);
    logic [15:0] d;
    logic        ok;
    u_host.read_reg(addr, d, ok);
    if (ok !== 1'b1) begin
      err_count++;
      tally_and_finish();
    end
    check(name, {16'h0000, d}, {16'h0000, exp});
  endtask : expect_rd

  // Returns the cycles spent, so a one-tick wait from a tick measures the drive period.
  task automatic wait_ticks(input int cnt, output int cyc);
    int seen;
    seen = 0;
    cyc  = 0;
    while (seen < cnt) begin
      @(posedge mclk);
      #1;
      cyc++;
      if (sine_tick === 1'b1) seen++;
      if (cyc > 1200 * cnt) begin
        err_count++;
        tally_and_finish();
      end
    end
  endtask : wait_ticks

  task automatic count_starts(output int cnt);
    cnt = 0;
    repeat (8) begin
      #1;
      if (sig_check_start === 1'b1) cnt++;
      @(posedge mclk);
    end
  endtask : count_starts

  task automatic t_regs();
    expect_rd(RD_STATUS, "status reset", 16'h0000);
    expect_rd(RD_BLANK, "blank reset", BLANK_RESET);
    expect_rd(8'h0F, "unknown code", 16'h0000);
    u_host.write_reg(RD_BLANK, 16'h0003);
    expect_rd(RD_BLANK, "blank written", 16'h0003);
  endtask : t_regs

  task automatic t_drive_frequency_select();
    int c;
    for (int k = 0; k < 4; k++) begin
      u_host.write_reg(RD_DRIVE_FREQUENCY_SELECT, 16'(k));
      wait_ticks(2, c);
      wait_ticks(1, c);
      check("drive period", c, PERIOD_NS[k] / MCLK_NS);
      check("wave high at tick", {31'h0, drive_wave}, 32'h0000_0001);
      repeat (PERIOD_NS[k] / MCLK_NS / 2) @(posedge mclk);
      #1;
      check("wave low at half", {31'h0, drive_wave}, 32'h0000_0000);
      expect_rd(RD_DRIVE_FREQUENCY_SELECT, "drive_frequency_select select", 16'(k));
    end
  endtask : t_drive_frequency_select

  task automatic t_blank(input int k);
    logic [15:0] b;
    int          c;
    b = 16'h0001 << MON_BIT[k];
    wait_ticks(1, c);
    @(posedge mclk);
    monitor_in <= 8'h01 << k;
    wait_ticks(2, c);
    expect_rd(RD_STATUS, "below count", 16'h0000);
    wait_ticks(1, c);
    // The counter reaches the count one edge after the tick and the flag one edge later.
    @(posedge mclk);
    expect_rd(RD_STATUS, "qualified", b);
    expect_rd(RD_STATUS, "still qualified", b);
    @(posedge mclk);
    monitor_in <= 8'h00;
    wait_ticks(1, c);
    expect_rd(RD_STATUS, "latched", b);
    expect_rd(RD_STATUS, "cleared", 16'h0000);
    wait_ticks(3, c);
  endtask : t_blank

  // Two ticks high, two low, two high: only a counter that counts down stays below three.
  task automatic t_updown();
    int c;
    wait_ticks(1, c);
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk);
      monitor_in <= (i == 1) ? 8'h00 : 8'h01;
      wait_ticks(2, c);
    end
    expect_rd(RD_STATUS, "up down", 16'h0000);
    @(posedge mclk);
    monitor_in <= 8'h00;
    wait_ticks(3, c);
  endtask : t_updown

  task automatic t_unblanked();
    @(posedge mclk);
    {regulator_fail_in, pin_short_in, clock_invalid_in} <= 3'h7;
    repeat (4) @(posedge mclk);
    {regulator_fail_in, pin_short_in, clock_invalid_in} <= 3'h0;
    repeat (4) @(posedge mclk);
    expect_rd(RD_STATUS, "unblanked", 16'h0A02);
    expect_rd(RD_STATUS, "unblanked read", 16'h0000);
  endtask : t_unblanked

  task automatic t_pins();
    u_host.write_reg(RD_PINSEL, 16'h0195);
    repeat (3) @(posedge mclk);
    #1;
    check("mux open", {31'h0, main_mux_open}, 32'h0000_0001);
    check("plus pin", {28'h0, diag_mux_plus}, 32'h0000_0005);
    check("minus pin", {28'h0, diag_mux_minus}, 32'h0000_0009);
    expect_rd(RD_PINSEL, "pin select", 16'h0195);
    u_host.write_reg(RD_PINSEL, 16'h0000);
    repeat (3) @(posedge mclk);
    #1;
    check("mux closed", {31'h0, main_mux_open}, 32'h0000_0000);
  endtask : t_pins

  task automatic t_accum();
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk);
      adc_valid  <= 1'b1;
      adc_q_sel  <= (i == 2);
      adc_sample <= (i == 0) ? 10'h005 : (i == 1) ? 10'h007 : 10'h003;
    end
    @(posedge mclk);
    adc_valid <= 1'b0;
    expect_rd(RD_I_DATA, "i sum", 16'h000C);
    expect_rd(RD_Q_DATA, "q sum", 16'h0003);
    expect_rd(RD_I_DATA, "i read clears", 16'h0000);
  endtask : t_accum

  task automatic t_signature();
    @(posedge mclk);
    {sig_done, sig_match} <= 2'b10;
    @(posedge mclk);
    {sig_done, sig_match} <= 2'b01;
    expect_rd(RD_STATUS, "sig fail", 16'h1000);
    expect_rd(RD_STATUS, "sig held", 16'h1000);
    @(posedge mclk);
    mem_reset_pulse <= 1'b1;
    @(posedge mclk);
    mem_reset_pulse <= 1'b0;
    count_starts(n);
    check("mem reset start", n, 1);
    expect_rd(RD_STATUS, "sig cleared", 16'h0000);
    u_host.write_reg(RD_DIVIDER, 16'h0005);
    count_starts(n);
    check("divider start", n, 1);
    expect_rd(RD_STATUS, "divider field", 16'(5) << ST_DIV_LSB);
    expect_rd(RD_DIVIDER, "divider reg", 16'h0005);
  endtask : t_signature

  initial begin
    mclk = 1'b0;
    rst_b = 1'b0;
    err_count = 0;
    total_checks = 0;
    monitor_in = 8'h00;
    {regulator_fail_in, pin_short_in, clock_invalid_in, mem_reset_pulse} = 4'h0;
    {sig_done, sig_match, adc_valid, adc_q_sel} = 4'h0;
    adc_sample = 10'h000;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    count_starts(n);
    check("power-on start", n, 1);
    t_regs();
    t_drive_frequency_select();
    for (int k = 0; k < N_MON; k++) t_blank(k);
    t_updown();
    t_unblanked();
    t_pins();
    t_accum();
    t_signature();
    tally_and_finish();
  end
endmodule : diag_blanking_and_flag_latch_tb
